// ---- hdl/otp_pkg.sv ----
package otp_pkg;

    // ----------------------------------------------------------------
    // APB register map
    // ----------------------------------------------------------------
    localparam logic [7:0] addr_control = 8'h00;
    localparam logic [7:0] addr_status = 8'h04;
    localparam logic [7:0] addr_option = 8'h08;
    localparam logic [7:0] addr_address = 8'h0c;
    localparam logic [7:0] addr_read_data = 8'h10;

    // Control register fields
    localparam int ctl_halt_bit = 0;
    localparam int ctl_stop_bit = 1;
    localparam int ctl_sup_en_bit = 2;
    localparam int ctl_protect_rd_bit = 3;

    // Option bit positions
    localparam int opt_protect = 0;
    localparam int opt_low_noise = 1;
    localparam int opt_latch_dis = 2;
    localparam int opt_watchdog = 3;
    localparam int opt_test_dis = 4;
    localparam int opt_count = 5;

    // Status fields
    localparam int st_prog_mode_bit = 0;
    localparam int st_mode_lsb = 1;

    localparam logic [9:0] addr_counter_reset = 10'h000;
    localparam logic [7:0] mem_erased = 8'hff;
    localparam logic [4:0] option_reset = 5'h00;

    // Low-noise clock limit, in ns, and as a pclk cycle count
    localparam int low_noise_period_ns = 250;
    localparam int pclk_period_ns = 4;
    localparam int low_noise_period_cycles = low_noise_period_ns / pclk_period_ns;

    typedef enum logic [2:0] {
        mode_idle = 3'b000,
        mode_read = 3'b001,
        mode_program = 3'b010,
        mode_verify = 3'b011,
        mode_option = 3'b100
    } mode_type;

    // Qualified programming pins after synchronisation
    typedef struct packed {
        logic array_select_n;
        logic drive_ctl;
        logic mode_sel_hv;
        logic mode_sel;
        logic vpp_hv;
        logic write_strobe_n;
        logic addr_clk;
        logic addr_clear;
    } prog_pins_type;

endpackage

// ---- hdl/pin_sync.sv ----
`timescale 1ns/100ps

// Two-stage synchroniser for a bank of asynchronous pins
module pin_sync #(
    parameter int width = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Data
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);

    logic [width-1:0] stage1;
    logic [width-1:0] next_stage1;
    logic [width-1:0] next_sync_out;

    always_comb begin
        next_stage1 = clk_en ? async_in : stage1;
        next_sync_out = clk_en ? stage1 : sync_out;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end

endmodule

// ---- hdl/otp_access.sv ----
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps

// What this block does
// - Programming mode reassigns osc and port pins
// - Read, program, verify decoded from pins
// - Option bits programmed by pin combinations
// - Latch-disable option turns off input keepers
// - Watchdog option forces supervision timer on
// - Test-disable option blocks programming mode entry
// - Protect blocks read mode (verify still reads), internal loads work
// - Protect never enables low noise
// - Low noise bypasses oscillator divide-by-two
// - Address counter increments per address clock
// - Clear pin high zeroes address counter
// - Drive control low makes data bus output
module otp_access (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Programming pins (asynchronous)
    input wire logic osc_in,
    input wire logic port3_line1,
    input wire logic port3_line2,
    input wire logic port3_line2_hv,
    input wire logic port3_line3_hv,
    input wire logic port0_line2,
    input wire logic addr_clk_pin,
    input wire logic addr_clear_pin,
    // Data bus
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // Oscillator and core clocking
    output logic osc_out_en,
    output logic sys_clk_en,
    // Option effects
    output logic auto_latch_en,
    output logic supervision_timer_run,
    output logic low_noise_active,
    // Internal program memory loads
    input wire logic load_req,
    input wire logic [9:0] load_addr,
    output logic [7:0] load_data
);

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    otp_pkg::prog_pins_type pins;
    logic [7:0] pins_raw;
    logic [7:0] data_sync;

    assign pins_raw = {osc_in, port3_line1, port3_line2_hv, port3_line2, port3_line3_hv,
                       port0_line2, addr_clk_pin, addr_clear_pin};

    pin_sync #(.width(8)) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .async_in(pins_raw),
        .sync_out(pins)
    );

    pin_sync #(.width(8)) u_data_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .async_in(data_in),
        .sync_out(data_sync)
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [4:0] option_fuse = otp_pkg::option_reset;
    logic [4:0] option_live;
    logic [7:0] mem [0:1023] = '{default: otp_pkg::mem_erased};
    logic [9:0] addr_count;
    logic addr_clk_q;
    logic strobe_q;
    logic [7:0] data_reg;
    logic data_oe_reg;
    logic sampled;
    logic [2:0] control;
    logic div_phase;
    logic [7:0] load_data_reg;
    logic [31:0] prdata_reg;
    otp_pkg::mode_type mode;

    logic [4:0] next_option_fuse;
    logic [4:0] next_option_live;
    logic [9:0] next_addr_count;
    logic [7:0] next_data_reg;
    logic next_data_oe_reg;
    logic next_sampled;
    logic [2:0] next_control;
    logic next_div_phase;
    logic [7:0] next_load_data_reg;
    logic [31:0] next_prdata_reg;
    logic mem_we;
    logic [4:0] fuse_set;
    logic prog_entry;

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    function automatic otp_pkg::mode_type decode_mode(input otp_pkg::prog_pins_type p);
        if (p.array_select_n) begin
            decode_mode = otp_pkg::mode_idle;
        end else if (p.mode_sel_hv && !p.drive_ctl && p.write_strobe_n) begin
            decode_mode = otp_pkg::mode_read;
        end else if (p.vpp_hv && p.mode_sel && p.drive_ctl) begin
            decode_mode = otp_pkg::mode_program;
        end else if (p.vpp_hv && p.mode_sel && !p.drive_ctl && p.write_strobe_n) begin
            decode_mode = otp_pkg::mode_verify;
        end else begin
            decode_mode = otp_pkg::mode_idle;
        end
    endfunction

    // Vpp pin at high voltage with select pin high marks option programming
    logic option_sel_hv;
    assign option_sel_hv = pins.vpp_hv && pins.array_select_n;

    // Entry refused once test-disable was latched at reset
    assign prog_entry = !option_live[otp_pkg::opt_test_dis];

    always_comb begin
        mode = prog_entry ? decode_mode(pins) : otp_pkg::mode_idle;
        if (prog_entry && option_sel_hv) begin
            mode = otp_pkg::mode_option;
        end
    end

    // Option selection from mode select level and drive level
    always_comb begin
        fuse_set = '0;
        if (mode == otp_pkg::mode_option && !pins.write_strobe_n && strobe_q) begin
            if (pins.mode_sel_hv && pins.drive_ctl) begin
                fuse_set[otp_pkg::opt_protect] = 1'b1;
            end else if (!pins.mode_sel_hv && pins.mode_sel && pins.drive_ctl) begin
                fuse_set[otp_pkg::opt_low_noise] = 1'b1;
            end else if (!pins.mode_sel_hv && pins.mode_sel && !pins.drive_ctl) begin
                fuse_set[otp_pkg::opt_latch_dis] = 1'b1;
            end else if (!pins.mode_sel && pins.drive_ctl) begin
                fuse_set[otp_pkg::opt_watchdog] = 1'b1;
            end else if (!pins.mode_sel && !pins.drive_ctl) begin
                fuse_set[otp_pkg::opt_test_dis] = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Array, counter and data bus
    // ----------------------------------------------------------------
    always_comb begin
        next_addr_count = addr_count;
        next_data_reg = data_reg;
        next_data_oe_reg = 1'b0;
        next_option_fuse = option_fuse | fuse_set;
        mem_we = 1'b0;
        if (mode != otp_pkg::mode_idle && mode != otp_pkg::mode_option) begin
            if (pins.addr_clear) begin
                next_addr_count = otp_pkg::addr_counter_reset;
            end else if (pins.addr_clk && !addr_clk_q) begin
                next_addr_count = addr_count + 10'h001;
            end
            next_data_oe_reg = !pins.drive_ctl;
            if (option_live[otp_pkg::opt_protect] && mode == otp_pkg::mode_read) begin
                next_data_reg = 8'h00;
            end else begin
                next_data_reg = mem[addr_count];
            end
            if (mode == otp_pkg::mode_program && !pins.write_strobe_n && strobe_q) begin
                mem_we = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_count <= otp_pkg::addr_counter_reset;
            data_reg <= 8'h00;
            data_oe_reg <= 1'b0;
            addr_clk_q <= 1'b0;
            strobe_q <= 1'b0;
        end else if (clk_en) begin
            addr_count <= next_addr_count;
            data_reg <= next_data_reg;
            data_oe_reg <= next_data_oe_reg;
            addr_clk_q <= pins.addr_clk;
            strobe_q <= pins.write_strobe_n;
        end
    end

    // OTP bits only clear to zero from erased state; no reset
    always_ff @(posedge pclk) begin
        if (clk_en && mem_we) begin
            mem[addr_count] <= mem[addr_count] & data_sync;
        end
    end

    // Fuses survive presetn; only programming sets them
    always_ff @(posedge pclk) begin
        if (clk_en) begin
            option_fuse <= next_option_fuse;
        end
    end

    // ----------------------------------------------------------------
    // Option sampling at reset release
    // ----------------------------------------------------------------
    always_comb begin
        next_sampled = 1'b1;
        next_option_live = sampled ? option_live : option_fuse;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sampled <= 1'b0;
            option_live <= otp_pkg::option_reset;
        end else if (clk_en) begin
            sampled <= next_sampled;
            option_live <= next_option_live;
        end
    end

    // ----------------------------------------------------------------
    // Core clocking and option effects
    // ----------------------------------------------------------------
    always_comb begin
        next_div_phase = low_noise_active ? 1'b0 : !div_phase;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_phase <= 1'b0;
        end else if (clk_en) begin
            div_phase <= next_div_phase;
        end
    end

    assign low_noise_active = option_live[otp_pkg::opt_low_noise];
    assign sys_clk_en = clk_en && (low_noise_active || div_phase);
    assign osc_out_en = !(mode != otp_pkg::mode_idle);
    assign auto_latch_en = !option_live[otp_pkg::opt_latch_dis];
    assign supervision_timer_run = (sampled && option_live[otp_pkg::opt_watchdog]) ||
                                   (control[otp_pkg::ctl_sup_en_bit] &&
                                    !control[otp_pkg::ctl_halt_bit] &&
                                    !control[otp_pkg::ctl_stop_bit]);
    assign data_out = data_reg;
    assign data_oe = data_oe_reg;
    assign load_data = load_data_reg;

    // Internal loads ignore the protect option
    always_comb begin
        next_load_data_reg = load_req ? mem[load_addr] : load_data_reg;
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    logic apb_access;
    assign apb_access = psel && penable;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_reg;

    always_comb begin
        next_control = control;
        next_prdata_reg = prdata_reg;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                otp_pkg::addr_control: next_prdata_reg = {29'h0, control};
                otp_pkg::addr_status: next_prdata_reg = {28'h0, mode, mode != otp_pkg::mode_idle};
                otp_pkg::addr_option: next_prdata_reg = {27'h0, option_live};
                otp_pkg::addr_address: next_prdata_reg = {22'h0, addr_count};
                otp_pkg::addr_read_data: next_prdata_reg = {24'h0, load_data_reg};
                default: next_prdata_reg = 32'h0000_0000;
            endcase
        end
        if (apb_access && pwrite && paddr == otp_pkg::addr_control) begin
            next_control = pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= 3'h0;
            prdata_reg <= 32'h0000_0000;
            load_data_reg <= 8'h00;
        end else if (clk_en) begin
            control <= next_control;
            prdata_reg <= next_prdata_reg;
            load_data_reg <= next_load_data_reg;
        end
    end

endmodule

// ---- verif/otp_access_sva.sv ----
`timescale 1ns/100ps

// ------
// Checker on pins and option outputs
// ------
module otp_access_sva (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Programming pins
    input wire logic osc_in,
    input wire logic port3_line1,
    input wire logic port3_line2_hv,
    input wire logic port3_line3_hv,
    // Outputs
    input wire logic data_oe,
    input wire logic osc_out_en,
    input wire logic sys_clk_en,
    input wire logic auto_latch_en,
    input wire logic low_noise_active
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [2:0] since_rst;
    logic [2:0] next_since_rst;

    always_comb begin
        next_since_rst = (since_rst == 3'h7) ? since_rst : since_rst + 3'h1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_rst <= 3'h0;
        end else begin
            since_rst <= next_since_rst;
        end
    end

    sequence s_fast; (low_noise_active && clk_en) [*3]; endsequence
    sequence s_slow; (!low_noise_active && clk_en) [*3] ##0 sys_clk_en; endsequence
    property p_fast_clk; s_fast |-> sys_clk_en; endproperty
    property p_slow_clk; s_slow |=> !sys_clk_en || !clk_en; endproperty
    property p_osc_normal; (!port3_line2_hv && !port3_line3_hv) [*8] |-> osc_out_en; endproperty
    property p_oe_osc; data_oe && $past(clk_en) |-> !$past(osc_out_en); endproperty
    property p_oe_drive; port3_line1 [*6] |-> !data_oe; endproperty
    property p_oe_select; osc_in [*6] |-> !data_oe; endproperty
    property p_ln_hold; since_rst == 3'h7 |-> $stable(low_noise_active); endproperty
    property p_latch_hold; since_rst == 3'h7 |-> $stable(auto_latch_en); endproperty

    a_fast_clk: assert property (p_fast_clk) else $error("core clock divided");
    a_slow_clk: assert property (p_slow_clk) else $error("core clock not halved");
    a_osc_normal: assert property (p_osc_normal) else $error("osc off");
    a_oe_osc: assert property (p_oe_osc) else $error("osc on in prog mode");
    a_oe_drive: assert property (p_oe_drive) else $error("bus driven as input");
    a_oe_select: assert property (p_oe_select) else $error("bus driven unselected");
    a_ln_hold: assert property (p_ln_hold) else $error("low noise changed");
    a_latch_hold: assert property (p_latch_hold) else $error("keeper changed");
endmodule

bind otp_access otp_access_sva i_sva (
    .pclk, .presetn, .clk_en, .osc_in, .port3_line1, .port3_line2_hv, .port3_line3_hv,
    .data_oe, .osc_out_en, .sys_clk_en, .auto_latch_en, .low_noise_active
);

// ---- verif/otp_programmer.sv ----
`timescale 1ns/100ps

// ------
// Programmer: requested mode to pin levels
// ------
module otp_programmer (
    // Requests
    input wire logic [2:0] mode,
    input wire logic [2:0] opt,
    input wire logic strobe,
    input wire logic step,
    input wire logic clr,
    input wire logic [7:0] wdata,
    // Pins
    output otp_pkg::prog_pins_type pins,
    output logic [7:0] data_in
);
    always_comb begin
        // Idle: select high, drive high, no high voltage, logic-level mode select
        pins = {1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, step, clr};
        case (mode)
            otp_pkg::mode_read: begin
                pins.array_select_n = 1'h0;
                pins.drive_ctl = 1'h0;
                pins.mode_sel_hv = 1'h1;
            end
            otp_pkg::mode_program, otp_pkg::mode_verify: begin
                pins.array_select_n = 1'h0;
                pins.drive_ctl = (mode == otp_pkg::mode_program);
                pins.vpp_hv = 1'h1;
                pins.write_strobe_n = !(strobe && mode == otp_pkg::mode_program);
            end
            otp_pkg::mode_option: begin
                pins.vpp_hv = 1'h1;
                pins.mode_sel_hv = (opt == 3'(otp_pkg::opt_protect));
                pins.mode_sel = (opt < 3'(otp_pkg::opt_watchdog));
                pins.drive_ctl = (opt != 3'(otp_pkg::opt_latch_dis))
                    && (opt != 3'(otp_pkg::opt_test_dis));
                pins.write_strobe_n = !strobe;
            end
            default: begin
            end
        endcase
        data_in = (mode == otp_pkg::mode_program) ? wdata : ~wdata;
    end
endmodule

// ---- verif/otp_access_tb_top.sv ----
`timescale 1ns/100ps

// ------
// Bench for the programming port
// ------
module otp_access_tb_top;
    localparam int pace = otp_pkg::low_noise_period_cycles;
    localparam int limit = 40000;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, data_oe;
    logic osc_out_en, sys_clk_en, auto_latch_en, supervision_timer_run, low_noise_active;
    logic load_req, strobe, step, clr;
    logic [2:0] mode, opt;
    logic [7:0] paddr, data_in, data_out, wdata, load_data, a0, d0;
    logic [9:0] load_addr;
    logic [31:0] pwdata, prdata, rd, pend, exp_opt;
    otp_pkg::prog_pins_type pins;
    int n_fail, checked, cyc;

    otp_access i_dut (
        .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .osc_in(pins.array_select_n), .port3_line1(pins.drive_ctl),
        .port3_line2(pins.mode_sel), .port3_line2_hv(pins.mode_sel_hv),
        .port3_line3_hv(pins.vpp_hv), .port0_line2(pins.write_strobe_n),
        .addr_clk_pin(pins.addr_clk), .addr_clear_pin(pins.addr_clear), .data_in,
        .data_out, .data_oe, .osc_out_en, .sys_clk_en, .auto_latch_en,
        .supervision_timer_run, .low_noise_active, .load_req, .load_addr, .load_data
    );
    otp_programmer i_prog (.mode, .opt, .strobe, .step, .clr, .wdata, .pins, .data_in);

    initial begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == limit) begin
            n_fail++;
            wrap_up;
        end
    end

    function automatic logic [31:0] status_of(input logic [2:0] m);
        return {28'h0, m, 1'h1};
    endfunction

    task automatic wrap_up;
        $display("checks %0d, failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic chk_reg(input logic [7:0] ad, input logic [31:0] exp);
        apb(1'h0, ad, 32'h0);
        cmp(rd, exp);
    endtask

    task automatic set_mode(input logic [2:0] m);
        mode <= m;
        wait_n(8);
    endtask

    task automatic seek(input logic [7:0] a);
        clr <= 1'h1;
        wait_n(8);
        clr <= 1'h0;
        wait_n(8);
        repeat (a) begin
            step <= 1'h1;
            wait_n(pace);
            step <= 1'h0;
            wait_n(pace);
        end
    endtask

    task automatic pulse_strobe;
        wait_n(8);
        strobe <= 1'h1;
        wait_n(8);
        strobe <= 1'h0;
        wait_n(8);
    endtask

    task automatic prog_byte(input logic [7:0] a, input logic [7:0] d);
        set_mode(otp_pkg::mode_program);
        seek(a);
        wdata <= d;
        cmp(data_oe, 1'h0);
        pulse_strobe;
    endtask

    task automatic prog_opt(input int o);
        opt <= 3'(o);
        set_mode(otp_pkg::mode_option);
        pulse_strobe;
        set_mode(otp_pkg::mode_idle);
        pend[o] = 1'h1;
    endtask

    task automatic rd_byte(input logic [2:0] m, input logic [7:0] a, input logic [7:0] exp);
        set_mode(m);
        seek(a);
        chk_reg(otp_pkg::addr_address, {24'h0, a});
        cmp({data_oe, data_out}, {1'h1, exp});
    endtask

    task automatic load_chk(input logic [7:0] a, input logic [7:0] exp);
        load_addr <= {2'h0, a};
        load_req <= 1'h1;
        wait_n(1);
        load_req <= 1'h0;
        wait_n(1);
        cmp(load_data, exp);
    endtask

    task automatic clk_chk(input logic ln);
        logic s;
        wait_n(1);
        s = sys_clk_en;
        wait_n(1);
        cmp({s, sys_clk_en}, ln ? 2'h3 : {s, ~s});
    endtask

    task automatic do_reset;
        presetn <= 1'h0;
        wait_n(20);
        presetn <= 1'h1;
        exp_opt = pend;
        wait_n(4);
    endtask

    initial begin
        {psel, penable, pwrite, load_req, strobe, step, clr} = 7'h0;
        presetn = 1'h0;
        clk_en = 1'h1;
        {paddr, wdata, opt, load_addr, pwdata} = 61'h0;
        mode = otp_pkg::mode_idle;
        {pend, exp_opt} = 64'h0;
        {n_fail, checked, cyc} = 96'h0;
        void'($urandom(32'hbb75c150));
        a0 = 8'($urandom_range(0, 6));
        d0 = 8'($urandom);
        do_reset;
        chk_reg(otp_pkg::addr_status, 32'h0);
        apb(1'h1, 8'h14, 32'hffffffff);
        chk_reg(8'h14, 32'h0);
        apb(1'h1, otp_pkg::addr_option, 32'h1f);
        chk_reg(otp_pkg::addr_option, exp_opt);
        cmp({osc_out_en, auto_latch_en, supervision_timer_run, low_noise_active}, 4'hc);
        apb(1'h1, otp_pkg::addr_control, 32'h4);
        cmp(supervision_timer_run, 1'h1);
        apb(1'h1, otp_pkg::addr_control, 32'h5);
        chk_reg(otp_pkg::addr_control, 32'h5);
        cmp(supervision_timer_run, 1'h0);
        clk_chk(1'h0);
        rd_byte(otp_pkg::mode_read, a0 + 8'h3, otp_pkg::mem_erased);
        cmp(osc_out_en, 1'h0);
        chk_reg(otp_pkg::addr_status, status_of(otp_pkg::mode_read));
        clr <= 1'h1;
        wait_n(8);
        chk_reg(otp_pkg::addr_address, 32'h0);
        clr <= 1'h0;
        prog_byte(a0, d0);
        prog_byte(a0 + 8'h1, 8'h00);
        rd_byte(otp_pkg::mode_verify, a0, d0);
        rd_byte(otp_pkg::mode_read, a0 + 8'h1, 8'h00);
        set_mode(otp_pkg::mode_idle);
        load_chk(a0, d0);
        prog_opt(otp_pkg::opt_protect);
        chk_reg(otp_pkg::addr_option, exp_opt);
        do_reset;
        chk_reg(otp_pkg::addr_option, exp_opt);
        cmp(low_noise_active, 1'h0);
        clk_chk(1'h0);
        rd_byte(otp_pkg::mode_read, a0, 8'h00);
        set_mode(otp_pkg::mode_idle);
        load_chk(a0, d0);
        for (int o = 1; o < 4; o++) prog_opt(o);
        do_reset;
        chk_reg(otp_pkg::addr_option, exp_opt);
        apb(1'h1, otp_pkg::addr_control, 32'h3);
        wait_n(4);
        cmp({low_noise_active, auto_latch_en, supervision_timer_run}, 3'h5);
        clk_chk(1'h1);
        prog_opt(otp_pkg::opt_test_dis);
        do_reset;
        chk_reg(otp_pkg::addr_option, exp_opt);
        set_mode(otp_pkg::mode_read);
        cmp({osc_out_en, data_oe}, 2'h2);
        chk_reg(otp_pkg::addr_status, 32'h0);
        prog_byte(a0 + 8'h2, 8'h5a);
        set_mode(otp_pkg::mode_idle);
        load_chk(a0 + 8'h2, otp_pkg::mem_erased);
        wrap_up;
    end
endmodule
